//--- core/cisub_core.sv
`timescale 1ns/1ps

// Notes on behaviour
// - rotate_right_carry shifts the operand right through carry and sets negative, zero, carry.
// - return_interrupt takes 9 cycles, pre-increments the stack and pulls flags, acc, index, pc.
// - return from subroutine takes 6 cycles, pulls pc high then low, flags untouched.
// - subtract_with_borrow takes acc minus memory minus carry and sets negative, zero, carry.
// - plain subtract takes acc minus memory with no borrow-in and sets negative, zero, carry.
// - store_accumulator writes acc to memory and sets negative and zero from it.
// - store_index writes the index register to memory and sets negative and zero from it.
// - stop takes 2 cycles, clears the interrupt mask and halts the oscillator.
// - wait takes 2 cycles, stops the cpu clock and clears only the interrupt mask.
// - software_trap pushes pc low, pc high, index, acc, flags, sets the mask, loads the vector.
// - copy_acc_to_index copies acc into index in 2 cycles, flags untouched.
// - copy_index_to_acc copies index into acc in 2 cycles, flags untouched.
// - test_zero_negative sets only negative and zero from the operand.
// - operand bytes follow the mode: one, high-low address, high-low offset, one, or none.
// - bit-test branches fetch a direct address then a relative offset added to the pc.
module cisub_core #(
  parameter logic [15:0] P_RESET_PC = cisub_pkg::RESET_PC,
  parameter logic [15:0] P_TRAP_VEC = cisub_pkg::TRAP_VEC
) (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_mem_rdata,
  input  wire logic        i_wake,
  output logic      [15:0] o_mem_addr,
  output logic      [7:0]  o_mem_wdata,
  output logic             o_mem_we,
  output logic             o_mem_re,
  output logic             o_osc_halt,
  output logic             o_cpu_clk_stop,
  output logic             o_instr_done,
  output logic             o_unsupported,
  output logic      [7:0]  o_acc,
  output logic      [7:0]  o_index,
  output logic      [7:0]  o_sp,
  output logic      [15:0] o_pc,
  output logic      [4:0]  o_flags
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic cisub_pkg::cisub_mode_t f_mode(input logic [7:0] op);
    case (op[7:4])
      4'h0:    f_mode = cisub_pkg::M_BTB;
      4'h3:    f_mode = cisub_pkg::M_DIR;
      4'h6:    f_mode = cisub_pkg::M_IX1;
      4'h7:    f_mode = cisub_pkg::M_IX;
      4'hA:    f_mode = cisub_pkg::M_IMM;
      4'hB:    f_mode = cisub_pkg::M_DIR;
      4'hC:    f_mode = cisub_pkg::M_EXT;
      4'hD:    f_mode = cisub_pkg::M_IX2;
      4'hE:    f_mode = cisub_pkg::M_IX1;
      4'hF:    f_mode = cisub_pkg::M_IX;
      default: f_mode = cisub_pkg::M_INH;
    endcase
  endfunction : f_mode

  function automatic cisub_pkg::cisub_kind_t f_kind(input logic [7:0] op);
    f_kind = cisub_pkg::K_NONE;
    if (op[7:4] == 4'h0) begin
      f_kind = cisub_pkg::K_BTB;
    end else if (op[7:4] >= cisub_pkg::HI_RMW && op[7:4] <= 4'h7) begin
      if (op[3:0] == cisub_pkg::LO_ROR) f_kind = cisub_pkg::K_ROR;
      if (op[3:0] == cisub_pkg::LO_TST) f_kind = cisub_pkg::K_TST;
    end else if (op[7:4] >= 4'hA) begin
      if (op[3:0] == cisub_pkg::LO_SUB) f_kind = cisub_pkg::K_SUB;
      if (op[3:0] == cisub_pkg::LO_SBC) f_kind = cisub_pkg::K_SBC;
      // no immediate form of a store
      if (op[7:4] != 4'hA && op[3:0] == cisub_pkg::LO_STA) f_kind = cisub_pkg::K_STA;
      if (op[7:4] != 4'hA && op[3:0] == cisub_pkg::LO_STX) f_kind = cisub_pkg::K_STX;
    end else begin
      case (op)
        cisub_pkg::OP_RTI:  f_kind = cisub_pkg::K_RTI;
        cisub_pkg::OP_RTS:  f_kind = cisub_pkg::K_RTS;
        cisub_pkg::OP_SWI:  f_kind = cisub_pkg::K_SWI;
        cisub_pkg::OP_STOP: f_kind = cisub_pkg::K_STOP;
        cisub_pkg::OP_WAIT: f_kind = cisub_pkg::K_WAIT;
        cisub_pkg::OP_TAX:  f_kind = cisub_pkg::K_TAX;
        cisub_pkg::OP_TXA:  f_kind = cisub_pkg::K_TXA;
        default:            f_kind = cisub_pkg::K_NONE;
      endcase
    end
  endfunction : f_kind

  function automatic logic [1:0] f_nbytes(input cisub_pkg::cisub_mode_t md);
    case (md)
      cisub_pkg::M_IMM, cisub_pkg::M_DIR, cisub_pkg::M_IX1: f_nbytes = 2'h1;
      cisub_pkg::M_EXT, cisub_pkg::M_IX2, cisub_pkg::M_BTB: f_nbytes = 2'h2;
      default:                                              f_nbytes = 2'h0;
    endcase
  endfunction : f_nbytes

  function automatic logic [3:0] f_cycles(input logic [7:0] op,
                                          input cisub_pkg::cisub_kind_t kd,
                                          input cisub_pkg::cisub_mode_t md);
    logic [2:0] rmw;
    rmw = 3'(op[7:4] - cisub_pkg::HI_RMW);
    case (kd)
      cisub_pkg::K_SUB, cisub_pkg::K_SBC: f_cycles = cisub_pkg::CYC_ALU[md];
      cisub_pkg::K_STA, cisub_pkg::K_STX: f_cycles = cisub_pkg::CYC_STORE[md];
      cisub_pkg::K_ROR:                   f_cycles = cisub_pkg::CYC_ROR[rmw];
      cisub_pkg::K_TST:                   f_cycles = cisub_pkg::CYC_TST[rmw];
      cisub_pkg::K_RTI:                   f_cycles = cisub_pkg::CYC_RTI;
      cisub_pkg::K_RTS:                   f_cycles = cisub_pkg::CYC_RTS;
      cisub_pkg::K_SWI:                   f_cycles = cisub_pkg::CYC_SWI;
      cisub_pkg::K_BTB:                   f_cycles = cisub_pkg::CYC_BTB;
      default:                            f_cycles = cisub_pkg::CYC_SHORT;
    endcase
  endfunction : f_cycles

  function automatic logic [4:0] f_nz(input logic [4:0] condition_flags, input logic [7:0] v);
    f_nz                 = condition_flags;
    f_nz[cisub_pkg::F_N] = v[7];
    f_nz[cisub_pkg::F_Z] = (v == 8'h00);
  endfunction : f_nz

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  cisub_pkg::cisub_state_t state_q, state_d;
  cisub_pkg::cisub_mode_t  md;
  cisub_pkg::cisub_kind_t  kd;
  logic [3:0]  step_q, step_d, cyc, dstep;
  logic [1:0]  nb;
  logic        last;
  logic [7:0]  op, op_q, op_d, acc_q, acc_d, x_q, x_d, sp_q, sp_d;
  logic [7:0]  tmp_q, tmp_d, rel_q, rel_d, wdata_q, wdata_d, val, rot, stv;
  logic [4:0]  ccr_q, ccr_d;
  logic [15:0] pc_q, pc_d, addr_q, addr_d, ea_q, ea_d, ea;
  logic [8:0]  diff;
  logic        we_q, we_d, re_q, re_d, halt_q, halt_d, cstop_q, cstop_d;
  logic        done_q, done_d, unsup_q, unsup_d, bitv;

  // opcode is live on the bus during step 0
  assign op    = (step_q == 4'h0) ? i_mem_rdata : op_q;
  assign md    = f_mode(op);
  assign kd    = f_kind(op);
  assign nb    = f_nbytes(md);
  assign cyc   = f_cycles(op, kd, md);
  assign last  = (step_q == cyc - 4'h1);
  assign dstep = (md == cisub_pkg::M_IMM || md == cisub_pkg::M_INH) ? 4'h1 : {2'h0, nb} + 4'h1;
  assign val   = (md == cisub_pkg::M_INH) ? (op[4] ? x_q : acc_q) : i_mem_rdata;
  assign rot   = {ccr_q[cisub_pkg::F_C], val[7:1]};
  assign stv   = (kd == cisub_pkg::K_STX) ? x_q : acc_q;
  assign bitv  = i_mem_rdata[op[3:1]];
  assign diff  = {1'b0, acc_q} - {1'b0, i_mem_rdata}
               - {8'h00, (kd == cisub_pkg::K_SBC) & ccr_q[cisub_pkg::F_C]};

  always_comb begin
    case (md)
      cisub_pkg::M_DIR: ea = {cisub_pkg::PAGE_ZERO, i_mem_rdata};
      cisub_pkg::M_BTB: ea = {cisub_pkg::PAGE_ZERO, tmp_q};
      cisub_pkg::M_EXT: ea = {tmp_q, i_mem_rdata};
      cisub_pkg::M_IX2: ea = {tmp_q, i_mem_rdata} + {8'h00, x_q};
      cisub_pkg::M_IX1: ea = {8'h00, i_mem_rdata} + {8'h00, x_q};
      default:          ea = {8'h00, x_q};
    endcase
  end

  always_comb begin
    state_d = state_q;   step_d  = step_q + 4'h1; op_d    = op_q;
    pc_d    = pc_q;      acc_d   = acc_q;         x_d     = x_q;
    sp_d    = sp_q;      ccr_d   = ccr_q;         tmp_d   = tmp_q;
    rel_d   = rel_q;     ea_d    = ea_q;          addr_d  = addr_q;
    wdata_d = wdata_q;   we_d    = 1'b0;          re_d    = 1'b0;
    halt_d  = halt_q;    cstop_d = cstop_q;       done_d  = 1'b0;
    unsup_d = 1'b0;
    case (state_q)
      cisub_pkg::S_RUN: begin
        if (step_q == 4'h0) begin
          op_d    = i_mem_rdata;
          pc_d    = pc_q + 16'h0001;
          unsup_d = (kd == cisub_pkg::K_NONE);
        end
        if (md != cisub_pkg::M_INH) begin
          // operand bytes come straight after the opcode, in pc order
          if (step_q != 4'h0 && step_q <= {2'h0, nb}) begin
            pc_d = pc_q + 16'h0001;
            if (step_q == 4'h1) tmp_d = i_mem_rdata;
            if (step_q == 4'h2) rel_d = i_mem_rdata;
          end
          if (step_q < {2'h0, nb}) begin
            addr_d = pc_d;
            re_d   = 1'b1;
          end else if (step_q == {2'h0, nb} && md != cisub_pkg::M_IMM) begin
            addr_d = ea;
            ea_d   = ea;
            if (kd == cisub_pkg::K_STA || kd == cisub_pkg::K_STX) begin
              we_d    = 1'b1;
              wdata_d = stv;
              ccr_d   = f_nz(ccr_q, stv);
            end else begin
              re_d = 1'b1;
            end
          end
        end
        if (step_q == dstep) begin
          case (kd)
            cisub_pkg::K_SUB, cisub_pkg::K_SBC: begin
              acc_d                  = diff[7:0];
              ccr_d                  = f_nz(ccr_q, diff[7:0]);
              ccr_d[cisub_pkg::F_C]  = diff[8];
            end
            cisub_pkg::K_ROR: begin
              ccr_d                  = f_nz(ccr_q, rot);
              ccr_d[cisub_pkg::F_C]  = val[0];
              if (md != cisub_pkg::M_INH) begin
                addr_d  = ea_q;
                we_d    = 1'b1;
                wdata_d = rot;
              end else if (op[4]) begin
                x_d = rot;
              end else begin
                acc_d = rot;
              end
            end
            cisub_pkg::K_TST:  ccr_d = f_nz(ccr_q, val);
            cisub_pkg::K_TAX:  x_d   = acc_q;
            cisub_pkg::K_TXA:  acc_d = x_q;
            cisub_pkg::K_STOP: ccr_d[cisub_pkg::F_I] = 1'b0;
            cisub_pkg::K_WAIT: ccr_d[cisub_pkg::F_I] = 1'b0;
            cisub_pkg::K_BTB: begin
              // carry mirrors the tested bit
              ccr_d[cisub_pkg::F_C] = bitv;
              if (bitv != op[0]) pc_d = pc_q + {{8{rel_q[7]}}, rel_q};
            end
            default: ;
          endcase
        end
        case (kd)
          cisub_pkg::K_RTI, cisub_pkg::K_RTS: begin
            if (step_q != 4'h0 && step_q <= ((kd == cisub_pkg::K_RTI) ? 4'h5 : 4'h2)) begin
              sp_d   = sp_q + 8'h01;
              addr_d = {cisub_pkg::PAGE_ZERO, sp_d};
              re_d   = 1'b1;
            end
            // rts pulls only the last two of the rti sequence;
            // its opcode and pad cycles must not load acc or index
            if (kd == cisub_pkg::K_RTI || step_q >= 4'h2) begin
              case (step_q + ((kd == cisub_pkg::K_RTS) ? 4'h3 : 4'h0))
                4'h2:    ccr_d = i_mem_rdata[4:0];
                4'h3:    acc_d = i_mem_rdata;
                4'h4:    x_d   = i_mem_rdata;
                4'h5:    tmp_d = i_mem_rdata;
                4'h6:    pc_d  = {tmp_q, i_mem_rdata};
                default: ;
              endcase
            end
          end
          cisub_pkg::K_SWI: begin
            if (step_q != 4'h0 && step_q <= 4'h5) begin
              addr_d = {cisub_pkg::PAGE_ZERO, sp_q};
              we_d   = 1'b1;
              sp_d   = sp_q - 8'h01;
            end
            case (step_q)
              4'h1:    wdata_d = pc_q[7:0];
              4'h2:    wdata_d = pc_q[15:8];
              4'h3:    wdata_d = x_q;
              4'h4:    wdata_d = acc_q;
              4'h5: begin
                wdata_d               = {cisub_pkg::CCR_PAD, ccr_q};
                ccr_d[cisub_pkg::F_I] = 1'b1;
              end
              4'h6: begin
                addr_d = P_TRAP_VEC;
                re_d   = 1'b1;
              end
              4'h7: begin
                tmp_d  = i_mem_rdata;
                addr_d = P_TRAP_VEC + 16'h0001;
                re_d   = 1'b1;
              end
              4'h8:    pc_d = {tmp_q, i_mem_rdata};
              default: ;
            endcase
          end
          default: ;
        endcase
        if (last) begin
          step_d = 4'h0;
          addr_d = pc_d;
          re_d   = 1'b1;
          we_d   = 1'b0;
          done_d = 1'b1;
          // the fetch is held back until a wake arrives
          if (kd == cisub_pkg::K_STOP) begin
            state_d = cisub_pkg::S_STOP;
            halt_d  = 1'b1;
            re_d    = 1'b0;
          end else if (kd == cisub_pkg::K_WAIT) begin
            state_d = cisub_pkg::S_WAIT;
            cstop_d = 1'b1;
            re_d    = 1'b0;
          end
        end
      end
      cisub_pkg::S_STOP, cisub_pkg::S_WAIT: begin
        step_d = 4'h0;
        if (i_wake) begin
          state_d = cisub_pkg::S_RUN;
          addr_d  = pc_q;
          re_d    = 1'b1;
          halt_d  = 1'b0;
          cstop_d = 1'b0;
        end
      end
      default: begin
        state_d = cisub_pkg::S_RUN;
        step_d  = 4'h0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cisub_pkg::S_RUN;  step_q  <= 4'h0;  op_q    <= 8'h00;
      pc_q    <= P_RESET_PC;        acc_q   <= 8'h00; x_q     <= 8'h00;
      sp_q    <= cisub_pkg::SP_RESET; ccr_q <= cisub_pkg::CCR_RESET;
      tmp_q   <= 8'h00;             rel_q   <= 8'h00; ea_q    <= 16'h0000;
      addr_q  <= P_RESET_PC;        wdata_q <= 8'h00; we_q    <= 1'b0;
      re_q    <= 1'b1;              halt_q  <= 1'b0;  cstop_q <= 1'b0;
      done_q  <= 1'b0;              unsup_q <= 1'b0;
    end else begin
      state_q <= state_d;  step_q  <= step_d;  op_q    <= op_d;
      pc_q    <= pc_d;     acc_q   <= acc_d;   x_q     <= x_d;
      sp_q    <= sp_d;     ccr_q   <= ccr_d;   tmp_q   <= tmp_d;
      rel_q   <= rel_d;    ea_q    <= ea_d;    addr_q  <= addr_d;
      wdata_q <= wdata_d;  we_q    <= we_d;    re_q    <= re_d;
      halt_q  <= halt_d;   cstop_q <= cstop_d; done_q  <= done_d;
      unsup_q <= unsup_d;
    end
  end

  assign o_mem_addr     = addr_q;
  assign o_mem_wdata    = wdata_q;
  assign o_mem_we       = we_q;
  assign o_mem_re       = re_q;
  assign o_osc_halt     = halt_q;
  assign o_cpu_clk_stop = cstop_q;
  assign o_instr_done   = done_q;
  assign o_unsupported  = unsup_q;
  assign o_acc          = acc_q;
  assign o_index        = x_q;
  assign o_sp           = sp_q;
  assign o_pc           = pc_q;
  assign o_flags        = ccr_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  sequence s_start(logic [7:0] opc);
    (state_q == cisub_pkg::S_RUN) && (step_q == 4'h0) && o_mem_re && (i_mem_rdata == opc);
  endsequence

  property p_rora;
    s_start(cisub_pkg::OP_ROR_ACC) |-> ##2 (o_acc == {$past(o_flags[0]), $past(o_acc[7:1])});
  endproperty
  a_rora: assert property (p_rora) else $error("rotate right result wrong");
  property p_rti;
    s_start(cisub_pkg::OP_RTI) |-> ##1 !o_instr_done [*8] ##1 o_instr_done;
  endproperty
  a_rti: assert property (p_rti) else $error("return from interrupt length wrong");
  property p_rts;
    s_start(cisub_pkg::OP_RTS) |-> ##6 (o_instr_done && o_flags == $past(o_flags, 6));
  endproperty
  a_rts: assert property (p_rts) else $error("return from subroutine wrong");
  property p_stop;
    s_start(cisub_pkg::OP_STOP) |-> ##2 (o_osc_halt && !o_flags[3] && !o_mem_re);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");
  property p_wait;
    s_start(cisub_pkg::OP_WAIT) |-> ##2 (o_cpu_clk_stop && !o_flags[3]
                                         && o_flags[2:0] == $past(o_flags[2:0], 2));
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not stop clock");
  property p_swi;
    s_start(cisub_pkg::OP_SWI) |-> ##2 o_mem_we [*5] ##4 (o_instr_done && o_flags[3]);
  endproperty
  a_swi: assert property (p_swi) else $error("software trap sequence wrong");
  property p_tax;
    s_start(cisub_pkg::OP_TAX) |-> ##2 (o_index == $past(o_acc) && o_flags == $past(o_flags, 2));
  endproperty
  a_tax: assert property (p_tax) else $error("acc to index copy wrong");
  property p_txa;
    s_start(cisub_pkg::OP_TXA) |-> ##2 (o_acc == $past(o_index) && o_flags == $past(o_flags, 2));
  endproperty
  a_txa: assert property (p_txa) else $error("index to acc copy wrong");
  property p_tsta;
    s_start(cisub_pkg::OP_TST_ACC) |-> ##3 (o_instr_done && o_flags[0] == $past(o_flags[0], 3)
                                            && o_flags[1] == (o_acc == 8'h00));
  endproperty
  a_tsta: assert property (p_tsta) else $error("test of acc wrong");

endmodule : cisub_core

//--- core/cisub_pkg.sv
package cisub_pkg;

  // ****************************************************************
  // opcodes handled as whole bytes, and the acc forms of ror and tst matched whole by the checks
  // ****************************************************************
  localparam logic [7:0] OP_RTI      = 8'h80;
  localparam logic [7:0] OP_RTS      = 8'h81;
  localparam logic [7:0] OP_SWI      = 8'h83;
  localparam logic [7:0] OP_STOP     = 8'h8E;
  localparam logic [7:0] OP_WAIT     = 8'h8F;
  localparam logic [7:0] OP_TAX      = 8'h97;
  localparam logic [7:0] OP_TXA      = 8'h9F;
  localparam logic [7:0] OP_ROR_ACC  = 8'h46;
  localparam logic [7:0] OP_TST_ACC  = 8'h4D;

  // ****************************************************************
  // low nibbles of the mode-column families, and the first read-modify-write high nibble
  // ****************************************************************
  localparam logic [3:0] LO_SUB = 4'h0;
  localparam logic [3:0] LO_SBC = 4'h2;
  localparam logic [3:0] LO_ROR = 4'h6;
  localparam logic [3:0] LO_STA = 4'h7;
  localparam logic [3:0] LO_TST = 4'hD;
  localparam logic [3:0] LO_STX = 4'hF;
  localparam logic [3:0] HI_RMW = 4'h3;

  // ****************************************************************
  // condition flags, stack, reset values
  // ****************************************************************
  localparam int         F_C        = 0;
  localparam int         F_Z        = 1;
  localparam int         F_N        = 2;
  localparam int         F_I        = 3;
  localparam int         F_H        = 4;
  localparam logic [2:0] CCR_PAD    = 3'h7;
  localparam logic [4:0] CCR_RESET  = 5'h08;
  localparam logic [7:0] SP_RESET   = 8'hFF;
  localparam logic [7:0] PAGE_ZERO  = 8'h00;
  localparam logic [15:0] RESET_PC  = 16'h0100;
  localparam logic [15:0] TRAP_VEC  = 16'hFFFC;

  // ****************************************************************
  // cycle counts, indexed by mode (imm dir ext ix2 ix1 ix)
  // or by high nibble minus 3 (dir acc index ix1 ix)
  // ****************************************************************
  localparam logic [3:0] CYC_ALU   [0:5] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
  localparam logic [3:0] CYC_STORE [0:5] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'h5, 4'h4};
  localparam logic [3:0] CYC_ROR   [0:4] = '{4'h5, 4'h3, 4'h3, 4'h6, 4'h5};
  localparam logic [3:0] CYC_TST   [0:4] = '{4'h4, 4'h3, 4'h3, 4'h5, 4'h4};
  localparam logic [3:0] CYC_RTI   = 4'h9;
  localparam logic [3:0] CYC_RTS   = 4'h6;
  localparam logic [3:0] CYC_SWI   = 4'hA;
  localparam logic [3:0] CYC_BTB   = 4'h5;
  localparam logic [3:0] CYC_SHORT = 4'h2;

  typedef enum logic [2:0] {
    M_IMM = 3'h0, M_DIR = 3'h1, M_EXT = 3'h2, M_IX2 = 3'h3,
    M_IX1 = 3'h4, M_IX  = 3'h5, M_INH = 3'h6, M_BTB = 3'h7
  } cisub_mode_t;

  typedef enum logic [3:0] {
    K_NONE, K_SUB, K_SBC, K_STA, K_STX, K_ROR, K_TST, K_RTI,
    K_RTS, K_SWI, K_STOP, K_WAIT, K_TAX, K_TXA, K_BTB
  } cisub_kind_t;

  typedef enum logic [2:0] {
    S_RUN  = 3'b001,
    S_STOP = 3'b010,
    S_WAIT = 3'b100
  } cisub_state_t;

endpackage : cisub_pkg

//--- testbench/cisub_mem.sv
`timescale 1ns/1ps
// ****************************************
// program, stack and data memory
// ****************************************
module cisub_mem (
  input  wire logic        i_clock,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_we,
  input  wire logic        i_re,
  output logic      [7:0]  o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  // idle bus shows inverted data so a stale byte never looks valid
  assign o_rdata = i_re ? mem[i_addr] : ~last_q;
  always_ff @(posedge i_clock) begin
    last_q <= o_rdata;
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule : cisub_mem

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  // ****************************************
  // core, memory, clock
  // ****************************************
  logic        i_clock, i_nrst, i_wake, we, re, halt, cstop, done;
  logic [7:0]  rdata, wdata, acc, idx, sp;
  logic [15:0] addr;
  logic [4:0]  flags;
  logic [15:0] a_done [0:15];
  int          t_done [0:15];
  int          n_mismatch, tests_run, cyc, n_done, tick;
  initial i_clock = 1'b0;
  always #25 i_clock = ~i_clock;
  cisub_mem m (.i_clock(i_clock), .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
    .o_rdata(rdata));
  cisub_core uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_mem_rdata(rdata), .i_wake(i_wake),
    .o_mem_addr(addr), .o_mem_wdata(wdata), .o_mem_we(we), .o_mem_re(re), .o_osc_halt(halt),
    .o_cpu_clk_stop(cstop), .o_instr_done(done), .o_unsupported(), .o_acc(acc),
    .o_index(idx), .o_sp(sp), .o_pc(), .o_flags(flags));
  // time and fetch address of the first 16 completions, for cycle counts
  always @(negedge i_clock) begin
    tick++;
    if (tick > 4000) begin
      n_mismatch++;
      $display("MISMATCH at %0t: run did not finish", $time);
      complete_run();
    end
    if (i_nrst !== 1'b1) begin
      cyc = 0;
      n_done = 0;
    end else begin
      cyc++;
      if (done === 1'b1 && n_done < 16) begin
        t_done[n_done] = cyc;
        a_done[n_done] = addr;
        n_done++;
      end
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // filler is an unsupported opcode, so a runaway core never writes
  task automatic load(input logic [7:0] prog [$]);
    i_nrst = 1'b0;
    foreach (m.mem[i]) m.mem[i] = 8'h9D;
    foreach (prog[i]) m.mem[16'h0100 + i] = prog[i];
  endtask : load
  task automatic go(input int n);
    repeat (4) @(negedge i_clock);
    i_nrst = 1'b1;
    while (n_done < n) @(negedge i_clock);
  endtask : go
  task automatic s_arith;
    logic [15:0] c [7] = '{16'h2, 16'h2, 16'h2, 16'h4, 16'h5, 16'h2, 16'h4};
    load('{8'h97, 8'hA0, 8'h05, 8'hA2, 8'h01, 8'h97, 8'hB7, 8'h40, 8'hC7, 8'h12, 8'h34, 8'h9F,
           8'hBF, 8'h41});
    go(8);
    foreach (c[k]) check(16'(t_done[k+1] - t_done[k]), c[k]);
    check(16'(acc), 16'h00F9);
    check(16'(idx), 16'h00F9);
    check(16'(m.mem[16'h0040]), 16'h00F9);
    check(16'(m.mem[16'h1234]), 16'h00F9);
    check(16'(m.mem[16'h0041]), 16'h00F9);
    check(16'(flags), 16'h000C);
  endtask : s_arith
  task automatic s_low_power;
    logic [15:0] c [4] = '{16'h2, 16'h3, 16'h3, 16'h2};
    load('{8'h97, 8'hA0, 8'h02, 8'h46, 8'h4D, 8'h8F, 8'h8E});
    go(5);
    foreach (c[k]) check(16'(t_done[k+1] - t_done[k]), c[k]);
    check(16'(acc), 16'h00FF);
    check(16'(flags), 16'h0004);
    check(16'(cstop), 16'h0001);
    i_wake = 1'b1;
    @(negedge i_clock);
    i_wake = 1'b0;
    while (halt !== 1'b1) @(negedge i_clock);
    check(16'(flags), 16'h0004);
  endtask : s_low_power
  task automatic s_trap;
    logic [15:0] c [4] = '{16'h2, 16'hA, 16'h9, 16'h6};
    load('{8'hA0, 8'h01, 8'h97, 8'h83, 8'h81});
    m.mem[16'hFFFC] = 8'h02;
    m.mem[16'hFFFD] = 8'h00;
    m.mem[16'h0200] = 8'h80;
    m.mem[16'h0000] = 8'h03;
    m.mem[16'h0001] = 8'h00;
    go(5);
    foreach (c[k]) check(16'(t_done[k+1] - t_done[k]), c[k]);
    check(a_done[2], 16'h0200);
    check(a_done[3], 16'h0104);
    check(a_done[4], 16'h0300);
    check({m.mem[16'h00FF], m.mem[16'h00FE]}, 16'h0401);
    check({m.mem[16'h00FD], m.mem[16'h00FC]}, 16'hFFFF);
    check(16'(m.mem[16'h00FB]), 16'h00ED);
    check({sp, 3'h0, flags}, 16'h010D);
    check({acc, idx}, 16'hFFFF);
  endtask : s_trap
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    i_nrst = 1'b0;
    i_wake = 1'b0;
    s_arith();
    s_low_power();
    s_trap();
    complete_run();
  end
endmodule : tb
